/* File: rtl/slw_pkg.sv */
/*
   Constants for the segment LCD waveform control block: register offsets,
   field positions, reset values and frame timing figures.
   Assumes an APB master with 32-bit data and word-aligned byte addresses.
*/
// Overview of operation
// [R1] Sixty-four display pins, all undriven (high impedance) from reset.
// [R2] Selected pins drive a waveform; common-line bit picks backplane, else frontplane.
// [R3] Up to eight backplanes can be active at once.
// [R4] Enable clear: pins off, timing stopped, top bias tied to supply.
// [R5] Enable set: enabled pins drive, backplanes follow duty, bias enabled.
// [R6] Control bit 6 picks crystal clock (0) or alternate clock (1).
// [R7] Frame = clock / ((duty+1) * 8 * (4+prescale) * Y), Y from duty table.
// [R8] Software keeps the panel clock between 30 kHz and 39.063 kHz.
// [R9] Duty field n uses n+1 backplanes; reset value is 011.
// [R10] Software changes source, prescale and duty only while enable is clear.
// [R11] With frame interrupt enable set, every frame start raises a request. Code sets status bit 0; irq_o rises only with mask bit 0 set.
// [R12] Enable is clear after reset so nothing is driven until configured.
package slw_pkg;
   localparam int unsigned PIN_COUNT = 64;
   localparam int unsigned ADDR_W    = 8;

   localparam logic [7:0] OFS_CTRL0  = 8'h00;
   localparam logic [7:0] OFS_CTRL1  = 8'h04;
   localparam logic [7:0] OFS_SEL_LO = 8'h08;
   localparam logic [7:0] OFS_SEL_HI = 8'h0C;
   localparam logic [7:0] OFS_COM_LO = 8'h10;
   localparam logic [7:0] OFS_COM_HI = 8'h14;
   localparam logic [7:0] OFS_STAT   = 8'h18;
   localparam logic [7:0] OFS_MASK   = 8'h1C;
   localparam logic [7:0] OFS_PHASE  = 8'h20;

   localparam int unsigned BIT_DRIVE_ON  = 7;
   localparam int unsigned BIT_SOURCE    = 6;
   localparam int unsigned BIT_PRESC_HI  = 5;
   localparam int unsigned BIT_PRESC_LO  = 3;
   localparam int unsigned BIT_DUTY_HI   = 2;
   localparam int unsigned BIT_IRQ_EN    = 7;
   localparam int unsigned BIT_FRAME_EVT = 0;

   localparam logic [7:0] CTRL0_RESET = 8'h03;
   localparam logic [7:0] CTRL1_RESET = 8'h00;

   // Panel clock ticks per backplane phase: 8 * (4 + prescale) * Y
   localparam int unsigned TICKS_BASE = 8;
   localparam int unsigned PRESC_BASE = 4;
   localparam int unsigned CNT_W      = 11;

   localparam int unsigned CLK_MIN_KHZ_X1000 = 30000;
   localparam int unsigned CLK_MAX_KHZ_X1000 = 39063;
endpackage

/* File: rtl/slw_waveform_ctrl.sv */
/*
   Segment LCD waveform control: APB register file, panel clock selection,
   frame timing, digital frontplane/backplane levels with per-pin enables,
   bias control levels and a frame interrupt.
   Assumes crystal and alternate clock levels arrive synchronous to
   core_clk_i and run far slower than it; analog bias and pads are outside.
*/
// The APB interface to the registers and the register offsets were decided locally.
`timescale 1ns/10ps
module slw_waveform_ctrl
   import slw_pkg::*;
(
   input  wire logic                  core_clk_i,
   input  wire logic                  rst_n_i,
   input  wire logic                  psel_i,
   input  wire logic                  penable_i,
   input  wire logic                  pwrite_i,
   input  wire logic [ADDR_W-1:0]     paddr_i,
   input  wire logic [31:0]           pwdata_i,
   output logic      [31:0]           prdata_o,
   output logic                       pready_o,
   output logic                       pslverr_o,
   input  wire logic                  crystal_clock_out_i,
   input  wire logic                  alt_clock_i,
   output logic      [PIN_COUNT-1:0]  pad_out_o,
   output logic      [PIN_COUNT-1:0]  pad_oe_o,
   output logic                       bias_enable_o,
   output logic                       top_bias_tie_o,
   output logic                       irq_o
);

   typedef struct packed {
      logic [31:0]           rdata;
      logic                  ready;
      logic                  slverr;
      logic [7:0]            ctl0;
      logic [7:0]            ctl1;
      logic [PIN_COUNT-1:0]  pin_sel;
      logic [PIN_COUNT-1:0]  com_sel;
      logic [7:0]            stat;
      logic [7:0]            mask;
      logic                  clk_prev;
      logic [CNT_W-1:0]      cnt;
      logic [2:0]            phase;
      logic                  pol;
      logic [PIN_COUNT-1:0]  pad_out;
      logic [PIN_COUNT-1:0]  pad_oe;
      logic                  bias_en;
      logic                  bias_tie;
      logic                  irq;
   } slw_state_type;

   localparam slw_state_type STATE_RESET = '{
      rdata:    32'h0000_0000,
      ready:    1'b0,
      slverr:   1'b0,
      ctl0:     CTRL0_RESET,
      ctl1:     CTRL1_RESET,
      pin_sel:  64'h0000_0000_0000_0000,
      com_sel:  64'h0000_0000_0000_0000,
      stat:     8'h00,
      mask:     8'h00,
      clk_prev: 1'b0,
      cnt:      11'h000,
      phase:    3'h0,
      pol:      1'b0,
      pad_out:  64'h0000_0000_0000_0000,
      pad_oe:   64'h0000_0000_0000_0000,
      bias_en:  1'b0,
      bias_tie: 1'b1,
      irq:      1'b0
   };

   slw_state_type s;
   slw_state_type next_s;
   logic [1:0]    rst_sync;
   logic          rst_n;

   // Y factor of the frame equation, indexed by duty
   function automatic logic [4:0] y_factor(input logic [2:0] duty);
      case (duty)
         3'h0:    y_factor = 5'h02;
         3'h1:    y_factor = 5'h02;
         3'h2:    y_factor = 5'h03;
         3'h3:    y_factor = 5'h03;
         3'h4:    y_factor = 5'h04;
         3'h5:    y_factor = 5'h05;
         3'h6:    y_factor = 5'h08;
         default: y_factor = 5'h10;
      endcase
   endfunction

   // Last count of one backplane phase: 8 * (4 + prescale) * Y - 1
   function automatic logic [CNT_W-1:0] phase_last(input logic [7:0] ctl);
      logic [CNT_W-1:0] div;
      div = CNT_W'(TICKS_BASE) * (CNT_W'(PRESC_BASE)
            + CNT_W'(ctl[BIT_PRESC_HI:BIT_PRESC_LO]))
            * CNT_W'(y_factor(ctl[BIT_DUTY_HI:0]));
      phase_last = div - 11'h001;
   endfunction

   always_ff @(posedge core_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         rst_sync <= 2'b00;
      else
         rst_sync <= {rst_sync[0], 1'b1};
   end
   assign rst_n = rst_sync[1];

   logic             wr_en;
   logic             rd_setup;
   logic             clk_sel;
   logic             tick;
   logic             drive_on;
   logic [2:0]       duty;
   logic             frame_start;
   logic [7:0]       w8;
   logic             hit;
   logic [31:0]      rd_val;

   always_comb
   begin
      next_s   = s;
      drive_on = s.ctl0[BIT_DRIVE_ON];
      duty     = s.ctl0[BIT_DUTY_HI:0];
      w8       = pwdata_i[7:0];
      wr_en    = psel_i & penable_i & s.ready & pwrite_i;
      rd_setup = psel_i & ~penable_i;

      // Source select picks which pin's rising edges count as panel clock
      clk_sel  = s.ctl0[BIT_SOURCE] ? alt_clock_i : crystal_clock_out_i; // R6
      next_s.clk_prev = clk_sel;
      tick = clk_sel & ~s.clk_prev;

      // Address decode, answered one cycle after setup
      hit    = 1'b1;
      rd_val = 32'h0000_0000;
      case (paddr_i)
         OFS_CTRL0:  rd_val = {24'h000000, s.ctl0};
         OFS_CTRL1:  rd_val = {24'h000000, s.ctl1};
         OFS_SEL_LO: rd_val = s.pin_sel[31:0];
         OFS_SEL_HI: rd_val = s.pin_sel[63:32];
         OFS_COM_LO: rd_val = s.com_sel[31:0];
         OFS_COM_HI: rd_val = s.com_sel[63:32];
         OFS_STAT:   rd_val = {24'h000000, s.stat};
         OFS_MASK:   rd_val = {24'h000000, s.mask};
         OFS_PHASE:  rd_val = {24'h000000, 3'h0, s.pol, 1'b0, s.phase};
         default:    hit = 1'b0;
      endcase
      next_s.ready  = rd_setup;
      next_s.slverr = rd_setup & ~hit;
      if (rd_setup)
         next_s.rdata = (hit && !pwrite_i) ? rd_val : 32'h0000_0000;

      // Frame timing runs only while the panel drive is on
      frame_start = 1'b0;
      if (!drive_on)
      begin
         next_s.cnt   = 11'h000; // R4
         next_s.phase = 3'h0; // R4
      end
      else if (tick)
      begin
         if (s.cnt >= phase_last(s.ctl0))
         begin
            next_s.cnt = 11'h000; // R7
            if (s.phase >= duty)
            begin
               next_s.phase = 3'h0; // R9
               next_s.pol   = ~s.pol;
               frame_start  = 1'b1;
            end
            else
               next_s.phase = s.phase + 3'h1; // R3
         end
         else
            next_s.cnt = s.cnt + 11'h001; // R7
      end

      if (wr_en && hit)
      begin
         case (paddr_i)
            OFS_CTRL0:  next_s.ctl0 = w8;
            OFS_CTRL1:  next_s.ctl1 = {w8[BIT_IRQ_EN], 7'h00};
            OFS_SEL_LO: next_s.pin_sel[31:0] = pwdata_i;
            OFS_SEL_HI: next_s.pin_sel[63:32] = pwdata_i;
            OFS_COM_LO: next_s.com_sel[31:0] = pwdata_i;
            OFS_COM_HI: next_s.com_sel[63:32] = pwdata_i;
            OFS_STAT:   next_s.stat = s.stat & ~w8;
            OFS_MASK:   next_s.mask = {7'h00, w8[BIT_FRAME_EVT]};
            default:    next_s.stat = next_s.stat;
         endcase
      end
      // Set after clear so an event in the clearing cycle survives
      if (frame_start && s.ctl1[BIT_IRQ_EN])
         next_s.stat[BIT_FRAME_EVT] = 1'b1; // R11
      next_s.irq = |(next_s.stat & next_s.mask);

      // Pin levels: backplane line k is active in phase k mod 8; polarity
      // flips every frame so the glass sees no net DC.
      for (int i = 0; i < PIN_COUNT; i++)
      begin
         if (s.com_sel[i] && (3'(i) == s.phase) && (3'(i) <= duty))
            next_s.pad_out[i] = ~s.pol; // R2
         else
            next_s.pad_out[i] = s.pol; // R2
      end
      next_s.pad_oe   = drive_on ? s.pin_sel : 64'h0000_0000_0000_0000; // R1 R4 R5
      next_s.bias_en  = drive_on; // R5
      next_s.bias_tie = ~drive_on; // R4
   end

   always_ff @(posedge core_clk_i or negedge rst_n)
   begin
      if (!rst_n)
         s <= STATE_RESET; // R12
      else
         s <= next_s;
   end

   assign prdata_o       = s.rdata;
   assign pready_o       = s.ready;
   assign pslverr_o      = s.slverr;
   assign pad_out_o      = s.pad_out;
   assign pad_oe_o       = s.pad_oe;
   assign bias_enable_o  = s.bias_en;
   assign top_bias_tie_o = s.bias_tie;
   assign irq_o          = s.irq;

   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (!rst_n);

   sequence drive_held;
      s.ctl0[BIT_DRIVE_ON] [*2];
   endsequence

   sequence frame_wrap;
      s.ctl0[BIT_DRIVE_ON] && tick && (s.phase >= duty)
         && (s.cnt >= phase_last(s.ctl0));
   endsequence

   sequence phase_end;
      s.ctl0[BIT_DRIVE_ON] && tick && (s.cnt >= phase_last(s.ctl0));
   endsequence

   pins_idle_off_a: assert property ( // R1
      !s.ctl0[BIT_DRIVE_ON] |=> pad_oe_o == 64'h0000_0000_0000_0000)
      else $error("pin enabled while panel drive off");

   oe_follows_sel_a: assert property ( // R2
      drive_held |-> pad_oe_o == $past(s.pin_sel))
      else $error("pin enables do not follow pin select");

   phase_in_duty_a: assert property ( // R9
      s.ctl0[BIT_DRIVE_ON] && $stable(s.ctl0) |-> s.phase <= duty)
      else $error("backplane phase beyond duty");

   bias_off_tie_a: assert property ( // R4
      !s.ctl0[BIT_DRIVE_ON] |=> top_bias_tie_o && !bias_enable_o
         && s.cnt == 11'h000)
      else $error("bias or timing active while off");

   bias_on_a: assert property ( // R5
      drive_held |-> bias_enable_o && !top_bias_tie_o)
      else $error("bias not enabled while driving");

   count_hold_a: assert property ( // R7
      s.ctl0[BIT_DRIVE_ON] && !tick |=> $stable(s.cnt) && $stable(s.phase))
      else $error("frame timing moved without a panel clock edge");

   src_edge_a: assert property ( // R6
      s.ctl0[BIT_DRIVE_ON] && s.ctl0[BIT_SOURCE] && $stable(alt_clock_i)
         && s.clk_prev == alt_clock_i |=> $stable(s.cnt))
      else $error("count moved without alternate clock edge");

   frame_irq_a: assert property ( // R11
      frame_wrap ##0 s.ctl1[BIT_IRQ_EN] |=> s.stat[BIT_FRAME_EVT]
         && (irq_o || !s.mask[BIT_FRAME_EVT]))
      else $error("frame start did not raise interrupt");

   no_irq_off_a: assert property ( // R11
      !s.ctl1[BIT_IRQ_EN] && !s.stat[BIT_FRAME_EVT] && !wr_en
         |=> !s.stat[BIT_FRAME_EVT])
      else $error("frame status set while interrupt disabled");

   reset_off_a: assert property ( // R12
      $rose(rst_n) |-> !s.ctl0[BIT_DRIVE_ON] && s.ctl0[BIT_DUTY_HI:0] == 3'h3)
      else $error("control register not at reset value");

   // Pads are registered, so level checks compare against the state one cycle back
   pad_reset_a: assert property ( // R1
      $rose(rst_n) |-> pad_oe_o == 64'h0000_0000_0000_0000
         && pad_out_o == 64'h0000_0000_0000_0000)
      else $error("display pins not released at reset");

   bp_active_a: assert property ( // R2
      s.com_sel[0] && s.phase == 3'h0 |=> pad_out_o[0] == !$past(s.pol))
      else $error("backplane line zero idle in its phase");

   fp_level_a: assert property ( // R2
      !s.com_sel[8] |=> pad_out_o[8] == $past(s.pol))
      else $error("frontplane pin off the frame polarity");

   line_seven_a: assert property ( // R3
      s.com_sel[7] && s.phase == 3'h7 && duty == 3'h7
         |=> pad_out_o[7] == !$past(s.pol))
      else $error("eighth backplane idle in its phase");

   line_off_a: assert property ( // R9
      s.com_sel[2] && duty < 3'h2 |=> pad_out_o[2] == $past(s.pol))
      else $error("backplane beyond duty became active");

   phase_step_a: assert property ( // R7
      phase_end ##0 (s.phase < duty)
         |=> s.phase == $past(s.phase) + 3'h1 && s.cnt == 11'h000)
      else $error("backplane phase did not advance at phase end");

   cnt_step_a: assert property ( // R7
      s.ctl0[BIT_DRIVE_ON] && tick && s.cnt < phase_last(s.ctl0)
         |=> s.cnt == $past(s.cnt) + 11'h001)
      else $error("panel clock edge not counted");

   frame_pol_a: assert property ( // R9
      frame_wrap |=> s.pol != $past(s.pol) && s.phase == 3'h0)
      else $error("frame wrap did not restart phase and flip polarity");

   src_xtal_a: assert property ( // R6
      s.ctl0[BIT_DRIVE_ON] && !s.ctl0[BIT_SOURCE] && s.clk_prev == crystal_clock_out_i
         |=> $stable(s.cnt))
      else $error("count moved without crystal clock edge");

   phase_off_a: assert property ( // R4
      !s.ctl0[BIT_DRIVE_ON] |=> s.phase == 3'h0)
      else $error("backplane phase moved while panel drive off");

   stat_clear_a: assert property ( // R11
      wr_en && paddr_i == OFS_STAT && pwdata_i[BIT_FRAME_EVT] && !frame_start
         |=> !s.stat[BIT_FRAME_EVT])
      else $error("status bit not cleared by writing one");

   irq_mask_a: assert property ( // R11
      !s.mask[BIT_FRAME_EVT] && !wr_en |=> !irq_o)
      else $error("interrupt raised while masked");

endmodule

/* File: bench/slw_glass_model.sv */
/*
   Passive segment glass seen from the display pins: resolves each electrode
   level and counts the driven pins. Assumes one core clock, no pull resistors.
*/
`timescale 1ns/10ps
module slw_glass_model
   import slw_pkg::*;
(
   input  wire logic                 core_clk_i,
   input  wire logic [PIN_COUNT-1:0] pad_out_i,
   input  wire logic [PIN_COUNT-1:0] pad_oe_i,
   output logic      [PIN_COUNT-1:0] line_level_o,
   output logic      [6:0]           driven_count_o
);
   logic [PIN_COUNT-1:0] last_level = '0;

   // A floating electrode keeps no value; toggle it so stale data never passes for drive
   always_comb
   begin
      driven_count_o = '0;
      for (int i = 0; i < PIN_COUNT; i++)
      begin
         line_level_o[i] = pad_oe_i[i] ? pad_out_i[i] : ~last_level[i];
         driven_count_o  = driven_count_o + 7'(pad_oe_i[i]);
      end
   end

   always_ff @(posedge core_clk_i)
      last_level <= line_level_o;
endmodule

/* File: bench/tb_segment_lcd_waveform_control.sv */
/*
   Self-checking bench for the waveform control block: APB master tasks,
   crystal and alternate clock levels, glass model on the pins.
   Assumes the APB slave answers in bounded time; frames are counted in core cycles.
*/
`timescale 1ns/10ps
module tb_segment_lcd_waveform_control
   import slw_pkg::*;
;
   logic                 core_clk_i = 1'b0;
   logic                 rst_n_i    = 1'b0;
   logic                 psel_i     = 1'b0;
   logic                 penable_i  = 1'b0;
   logic                 pwrite_i   = 1'b0;
   logic [ADDR_W-1:0]    paddr_i    = '0;
   logic [31:0]          pwdata_i   = '0;
   logic                 xtal       = 1'b0;
   logic                 alt        = 1'b0;
   logic                 xtal_run   = 1'b1;
   logic                 alt_run    = 1'b0;
   logic [31:0]          prdata_o;
   logic                 pready_o;
   logic                 pslverr_o;
   logic [PIN_COUNT-1:0] pad_out_o;
   logic [PIN_COUNT-1:0] pad_oe_o;
   logic                 bias_enable_o;
   logic                 top_bias_tie_o;
   logic                 irq_o;
   logic [PIN_COUNT-1:0] line_level;
   logic [6:0]           driven;
   logic [31:0]          rd;
   logic                 err;
   int                   cyc     = 0;
   int                   n_fail  = 0;
   int                   n_tests = 0;

   slw_waveform_ctrl dut_u (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i),
      .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
      .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
      .crystal_clock_out_i(xtal), .alt_clock_i(alt), .pad_out_o(pad_out_o),
      .pad_oe_o(pad_oe_o), .bias_enable_o(bias_enable_o), .top_bias_tie_o(top_bias_tie_o),
      .irq_o(irq_o));

   slw_glass_model glass_u (.core_clk_i(core_clk_i), .pad_out_i(pad_out_o),
      .pad_oe_i(pad_oe_o), .line_level_o(line_level), .driven_count_o(driven));

   initial
   begin
      forever #4 core_clk_i = ~core_clk_i;
   end

   // Crystal edge every 4 core cycles, alternate every 8
   always @(posedge core_clk_i)
   begin
      cyc <= cyc + 1;
      if (xtal_run && cyc % 2 == 0) xtal <= ~xtal;
      if (alt_run && cyc % 4 == 0) alt <= ~alt;
   end

   task automatic results;
      $display("tests %0d failures %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("mismatch %s expected %0h seen %0h", what, exp, seen);
      end
   endtask

   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int k;
      logic done;
      k = 0;
      done = 1'b0;
      @(posedge core_clk_i);
      psel_i    <= 1'b1;
      pwrite_i  <= wr;
      paddr_i   <= a;
      pwdata_i  <= d;
      @(posedge core_clk_i);
      penable_i <= 1'b1;
      // Answer is looked at mid-cycle: it stands unchanged up to the next rising edge
      while (!done && k < 20)
      begin
         @(negedge core_clk_i);
         done = (pready_o === 1'b1);
         rd   = prdata_o;
         err  = pslverr_o;
         @(posedge core_clk_i);
         k++;
      end
      if (!done)
      begin
         n_fail++;
         results();
      end
      psel_i    <= 1'b0;
      penable_i <= 1'b0;
   endtask

   task automatic wait_irq(output int t);
      int k;
      k = 0;
      repeat (2) @(posedge core_clk_i);
      @(negedge core_clk_i);
      while (irq_o !== 1'b1 && k < 5000)
      begin
         @(negedge core_clk_i);
         k++;
      end
      if (k >= 5000)
      begin
         n_fail++;
         results();
      end
      t = cyc;
   endtask

   task automatic t_reset;
      apb(1'b0, OFS_CTRL0, '0);
      chk("ctrl0", 64'(rd), 64'(CTRL0_RESET));
      chk("pad_oe", pad_oe_o, '0);
      chk("driven", 64'(driven), 64'h0);
      chk("bias", 64'({top_bias_tie_o, bias_enable_o}), 64'h2);
      apb(1'b0, 8'h40, '0);
      chk("unmapped", 64'({err, rd}), 64'h1_0000_0000);
   endtask

   task automatic t_frame(input logic [31:0] cfg, input logic [63:0] period);
      int t0;
      int t1;
      apb(1'b1, OFS_CTRL0, cfg);
      apb(1'b1, OFS_CTRL0, cfg | 32'h80);
      repeat (2) @(posedge core_clk_i);
      chk("pad_oe on", pad_oe_o, 64'h0000_0000_FFFF_FFFF);
      chk("bias on", 64'({top_bias_tie_o, bias_enable_o}), 64'h1);
      chk("driven on", 64'(driven), 64'd32);
      wait_irq(t0);
      apb(1'b1, OFS_STAT, 32'h1);
      wait_irq(t1);
      chk("frame cycles", 64'(t1 - t0), period);
      // Clear the last event so the next scenario does not start on a stale request
      apb(1'b1, OFS_STAT, 32'h1);
      apb(1'b1, OFS_CTRL0, cfg);
      repeat (2) @(posedge core_clk_i);
      chk("pad_oe off", pad_oe_o, '0);
      chk("bias off", 64'({top_bias_tie_o, bias_enable_o}), 64'h2);
      apb(1'b0, OFS_PHASE, '0);
      chk("phase held", 64'(rd[2:0]), 64'h0);
   endtask

   // Duty 7, prescale 0: 8 * 4 * 16 crystal edges of 4 cycles per phase, so
   // sampling every 2048 cycles lands in each of the eight phases in turn
   task automatic t_eight;
      int n;
      logic [7:0] seen;
      seen = 8'h00;
      apb(1'b1, OFS_COM_LO, 32'hFF);
      apb(1'b1, OFS_CTRL0, 32'h87);
      repeat (8)
      begin
         repeat (2048) @(posedge core_clk_i);
         @(negedge core_clk_i);
         n = 0;
         for (int i = 0; i < 8; i++)
            if (line_level[i] !== line_level[8])
            begin
               n++;
               seen[i] = 1'b1;
            end
         chk("active lines", 64'(n), 64'h1);
      end
      chk("lines visited", 64'(seen), 64'hFF);
      apb(1'b1, OFS_CTRL0, 32'h07);
   endtask

   task automatic t_mask;
      apb(1'b1, OFS_MASK, 32'h0);
      apb(1'b1, OFS_CTRL0, 32'h80);
      apb(1'b1, OFS_STAT, 32'h1);
      repeat (600) @(posedge core_clk_i);
      chk("irq masked", 64'(irq_o), 64'h0);
      apb(1'b0, OFS_STAT, '0);
      chk("status set", 64'(rd[0]), 64'h1);
      apb(1'b1, OFS_CTRL1, 32'h0);
      apb(1'b1, OFS_STAT, 32'h1);
      repeat (600) @(posedge core_clk_i);
      apb(1'b0, OFS_STAT, '0);
      chk("no event", 64'(rd[0]), 64'h0);
   endtask

   initial
   begin
      repeat (3) @(posedge core_clk_i);
      rst_n_i <= 1'b1;
      repeat (3) @(posedge core_clk_i);
      t_reset();
      apb(1'b1, OFS_SEL_LO, 32'hFFFF_FFFF);
      apb(1'b1, OFS_COM_LO, 32'h3);
      apb(1'b1, OFS_CTRL1, 32'h80);
      apb(1'b1, OFS_MASK, 32'h1);
      // Duty 1, prescale 0: 2 * 8 * 4 * 2 crystal edges of 4 cycles
      t_frame(32'h01, 64'd512);
      alt_run  <= 1'b1;
      xtal_run <= 1'b0;
      // Alternate source, duty 0: 1 * 8 * 4 * 2 edges of 8 cycles
      t_frame(32'h40, 64'd512);
      xtal_run <= 1'b1;
      t_eight();
      t_mask();
      results();
   end
endmodule
